// ==== gsr_pkg.sv ====
// Shared constants, types and helpers for the generic serial register link.
package gsr_pkg;

	// Frame field widths in bits.
	localparam int HDR_BITS  = 16;
	localparam int WORD_BITS = 32;
	localparam int ADDR_W    = 13;

	// Last bit index of each field, matched against the bit counter.
	localparam logic [5:0] HDR_LAST  = 6'h0F;
	localparam logic [5:0] BYTE_LAST = 6'h07;
	localparam logic [5:0] WORD_LAST = 6'h1F;

	// Header coding: start bits, then direction, then word address.
	localparam logic [1:0] START_CODE = 2'h2;
	localparam logic       DIR_WRITE  = 1'h1;

	// Check code: x^8 + x^2 + x + 1, seeded with zero.
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_SEED = 8'h00;

	// Strap levels and the settle time before the straps are caught.
	localparam logic       CRC_ON_LEVEL  = 1'h1;
	localparam logic       GENERIC_LEVEL = 1'h1;
	localparam logic [1:0] STRAP_WAIT    = 2'h3;

	// Addresses with special handling.
	localparam logic [12:0] ADDR_TX_FLEN = 13'h0030;
	localparam logic [12:0] ADDR_TX_DATA = 13'h0032;
	localparam logic [12:0] ADDR_RX_DATA = 13'h0090;
	localparam logic [12:0] ADDR_PHY_MIN = 13'h1000;

	// Bytes in one word, used to count frame bytes.
	localparam logic [15:0] WORD_BYTES = 16'h0004;

	// Serial clock made by the host: period and system clock period.
	localparam int SYS_PERIOD_NS  = 25;
	localparam int SCLK_PERIOD_NS = 200;
	localparam int SCLK_HALF      = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);

	typedef enum logic [2:0] {
		PH_HDR,
		PH_HCRC,
		PH_TA,
		PH_DATA,
		PH_DCRC,
		PH_IDLE
	} gsr_phase_t;

	typedef enum logic [2:0] {
		ACC_RW,
		ACC_RO,
		ACC_WO,
		ACC_W1C,
		ACC_RO_LL,
		ACC_RO_LH,
		ACC_RW_SC
	} gsr_access_t;

	// Check code over the n leading bits of d, most significant first.
	function automatic logic [7:0] crc8(input logic [31:0] d, input int n);
		logic [7:0] c;
		c = CRC_SEED;
		for (int i = 0; i < 32; i++)
		begin
			if (i < n)
				c = {c[6:0], 1'b0} ^ ((c[7] ^ d[31 - i]) ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	function automatic logic [5:0] field_last(input gsr_phase_t p);
		case (p)
			PH_HDR:  return HDR_LAST;
			PH_DATA: return WORD_LAST;
			default: return BYTE_LAST;
		endcase
	endfunction

	// Frame data ports carry no per-word check byte.
	function automatic logic is_data_space(input logic [12:0] a);
		return (a == ADDR_TX_DATA) || (a == ADDR_RX_DATA);
	endfunction

	// Valid byte lanes of a frame word; the first byte sits in bits 31:24.
	function automatic logic [3:0] byte_mask(input logic [15:0] len,
		input logic [15:0] done);
		logic [15:0] rem;
		rem = (done >= len) ? 16'h0000 : len - done;
		case (rem)
			16'h0000: return 4'h0;
			16'h0001: return 4'h8;
			16'h0002: return 4'hC;
			16'h0003: return 4'hE;
			default:  return 4'hF;
		endcase
	endfunction

endpackage

// ==== gsr_spi_if.sv ====
// Four-wire serial link between the host end and the device end.
`timescale 1ns/1ps
interface gsr_spi_if;
	logic sclk;
	logic cs_n;
	logic sdi;
	logic sdo_drv;
	logic sdo_oe;
	// Board level on the shared output line while the device does not drive.
	logic sdo_strap;
	logic sdo;

	assign sdo = sdo_oe ? sdo_drv : sdo_strap;

	modport dev (
		input  sclk,
		input  cs_n,
		input  sdi,
		input  sdo,
		output sdo_drv,
		output sdo_oe
	);

	modport host (
		output sclk,
		output cs_n,
		output sdi,
		input  sdo
	);
endinterface

// ==== gsr_dev.sv ====
// Device end: serial link decoder driving a word-wide register port.
`timescale 1ns/1ps
module gsr_dev (
	// Clock and reset
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_i,
	// Serial link
	gsr_spi_if.dev                    spi,
	// Configuration pins and status
	input  wire logic                 proto_cfg_i,
	output logic                      crc_en_o,
	output logic                      link_err_o,
	// Register port
	output logic                      reg_wr_o,
	output logic                      reg_rd_o,
	output logic [12:0]               reg_addr_o,
	output logic [31:0]               reg_wdata_o,
	output logic [3:0]                reg_be_o,
	output logic                      phy_sel_o,
	input  wire gsr_pkg::gsr_access_t reg_kind_i,
	input  wire logic [31:0]          reg_rdata_i
);

	logic                sclk_s1, sclk_s2, sclk_s3;
	logic                cs_s1, cs_s2;
	logic                sdi_s1, sdi_s2;
	logic                strap_s1, strap_s2;
	logic                proto_s1, proto_s2;
	logic [1:0]          strap_cnt_r;
	logic                crc_en_r;
	logic                generic_r;
	gsr_pkg::gsr_phase_t phase_r;
	logic [5:0]          cnt_r;
	logic [15:0]         hdr_r;
	logic                dir_r;
	logic [12:0]         addr_r;
	logic [31:0]         sh_in_r;
	logic [31:0]         wbuf_r;
	logic [31:0]         sh_out_r;
	logic [7:0]          rcrc_r;
	logic                sdo_r;
	logic                sdo_oe_r;
	logic                wr_pend_r;
	logic                rd_pend_r;
	logic                err_r;
	logic [15:0]         flen_r;
	logic [15:0]         txcnt_r;

	logic        active, rise, fall, last, wcrc, is_wr;
	logic        start_bad, hcrc_bad, dcrc_bad;
	logic        word_end, wr_go, rd_go;
	logic [31:0] word, wdat, rd_val;
	logic [12:0] next_addr;
	logic [3:0]  mask;

	// The first stage of each synchroniser feeds only the second.
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			cs_s1   <= 1'b1;
			cs_s2   <= 1'b1;
		end
		else
		begin
			sclk_s1 <= spi.sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_s1   <= spi.cs_n;
			cs_s2   <= cs_s1;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		sdi_s1   <= spi.sdi;
		sdi_s2   <= sdi_s1;
		strap_s1 <= spi.sdo;
		strap_s2 <= strap_s1;
		proto_s1 <= proto_cfg_i;
		proto_s2 <= proto_s1;
	end

	// Straps are caught once the synchronisers hold settled pin levels.
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			strap_cnt_r <= 2'h0;
			crc_en_r    <= 1'b0;
			generic_r   <= 1'b0;
		end
		else if (strap_cnt_r != gsr_pkg::STRAP_WAIT)
		begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == gsr_pkg::STRAP_WAIT - 2'h1)
			begin
				crc_en_r  <= (strap_s2 == gsr_pkg::CRC_ON_LEVEL);
				generic_r <= (proto_s2 == gsr_pkg::GENERIC_LEVEL);
			end
		end
	end

	assign active = ~cs_s2 & generic_r;
	assign rise   = active & sclk_s2 & ~sclk_s3;
	assign fall   = active & ~sclk_s2 & sclk_s3;
	assign word   = {sh_in_r[30:0], sdi_s2};
	assign last   = rise && (cnt_r == gsr_pkg::field_last(phase_r));
	assign is_wr  = (dir_r == gsr_pkg::DIR_WRITE);
	assign wcrc   = crc_en_r && !gsr_pkg::is_data_space(addr_r);
	assign start_bad = (word[15:14] != gsr_pkg::START_CODE);
	assign hcrc_bad  = gsr_pkg::crc8({hdr_r, 16'h0000}, gsr_pkg::HDR_BITS)
		!= word[7:0];
	assign dcrc_bad  = gsr_pkg::crc8(wbuf_r, gsr_pkg::WORD_BITS) != word[7:0];
	assign word_end  = last && ((phase_r == gsr_pkg::PH_DATA && !wcrc)
		|| phase_r == gsr_pkg::PH_DCRC);
	assign wr_go = word_end && is_wr
		&& !(phase_r == gsr_pkg::PH_DCRC && dcrc_bad);
	assign rd_go = (last && phase_r == gsr_pkg::PH_TA) || (word_end && !is_wr);
	assign wdat  = (phase_r == gsr_pkg::PH_DCRC) ? wbuf_r : word;
	assign next_addr = gsr_pkg::is_data_space(addr_r) ? addr_r
		: addr_r + 13'h0001;
	assign mask = (addr_r == gsr_pkg::ADDR_TX_DATA)
		? gsr_pkg::byte_mask(flen_r, txcnt_r) : 4'hF;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || !active)
		begin
			phase_r <= gsr_pkg::PH_HDR;
			cnt_r   <= 6'h00;
		end
		else if (rise)
		begin
			cnt_r <= last ? 6'h00 : cnt_r + 6'h01;
			if (last)
			begin
				case (phase_r)
					gsr_pkg::PH_HDR:
						if (start_bad)
							phase_r <= gsr_pkg::PH_IDLE;
						else if (crc_en_r)
							phase_r <= gsr_pkg::PH_HCRC;
						else if (word[13] == gsr_pkg::DIR_WRITE)
							phase_r <= gsr_pkg::PH_DATA;
						else
							phase_r <= gsr_pkg::PH_TA;
					gsr_pkg::PH_HCRC:
						if (hcrc_bad)
							phase_r <= gsr_pkg::PH_IDLE;
						else if (is_wr)
							phase_r <= gsr_pkg::PH_DATA;
						else
							phase_r <= gsr_pkg::PH_TA;
					gsr_pkg::PH_TA:
						phase_r <= gsr_pkg::PH_DATA;
					gsr_pkg::PH_DATA:
						if (wcrc)
							phase_r <= gsr_pkg::PH_DCRC;
					gsr_pkg::PH_DCRC:
						if (is_wr && dcrc_bad)
							phase_r <= gsr_pkg::PH_IDLE;
						else
							phase_r <= gsr_pkg::PH_DATA;
					default:
						phase_r <= gsr_pkg::PH_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			hdr_r  <= 16'h0000;
			dir_r  <= 1'b0;
			addr_r <= 13'h0000;
		end
		else if (last && phase_r == gsr_pkg::PH_HDR)
		begin
			hdr_r  <= word[15:0];
			dir_r  <= word[13];
			addr_r <= word[12:0];
		end
		else if (word_end)
			addr_r <= next_addr;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			sh_in_r <= 32'h0000_0000;
			wbuf_r  <= 32'h0000_0000;
		end
		else if (rise)
		begin
			sh_in_r <= word;
			if (last && phase_r == gsr_pkg::PH_DATA)
				wbuf_r <= word;
		end
	end

	// words to the register port; frame data writes carry only the valid byte lanes
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			wr_pend_r   <= 1'b0;
			rd_pend_r   <= 1'b0;
			reg_addr_o  <= 13'h0000;
			reg_wdata_o <= 32'h0000_0000;
			reg_be_o    <= 4'h0;
			phy_sel_o   <= 1'b0;
		end
		else
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			if (wr_go)
			begin
				wr_pend_r   <= (mask != 4'h0);
				reg_addr_o  <= addr_r;
				reg_wdata_o <= wdat;
				reg_be_o    <= mask;
				phy_sel_o   <= (addr_r >= gsr_pkg::ADDR_PHY_MIN);
			end
			else if (rd_go)
			begin
				rd_pend_r  <= 1'b1;
				reg_addr_o <= (phase_r == gsr_pkg::PH_TA) ? addr_r : next_addr;
				reg_be_o   <= 4'hF;
				phy_sel_o  <= (((phase_r == gsr_pkg::PH_TA) ? addr_r : next_addr)
					>= gsr_pkg::ADDR_PHY_MIN);
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			flen_r  <= 16'h0000;
			txcnt_r <= 16'h0000;
		end
		else if (wr_go && addr_r == gsr_pkg::ADDR_TX_FLEN)
		begin
			flen_r  <= wdat[15:0];
			txcnt_r <= 16'h0000;
		end
		else if (wr_go && addr_r == gsr_pkg::ADDR_TX_DATA)
			txcnt_r <= txcnt_r + gsr_pkg::WORD_BYTES;
	end

	// read-only kinds never see a write
	assign reg_wr_o = wr_pend_r && (reg_kind_i == gsr_pkg::ACC_RW
		|| reg_kind_i == gsr_pkg::ACC_WO || reg_kind_i == gsr_pkg::ACC_W1C
		|| reg_kind_i == gsr_pkg::ACC_RW_SC);
	assign reg_rd_o = rd_pend_r;
	assign rd_val   = (reg_kind_i == gsr_pkg::ACC_WO) ? 32'h0000_0000
		: reg_rdata_i;

	// Read data is loaded two system clocks after the serial edge, well
	// before the falling edge that presents its first bit.
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			sh_out_r <= 32'h0000_0000;
			rcrc_r   <= 8'h00;
		end
		else if (rd_pend_r)
		begin
			sh_out_r <= rd_val;
			rcrc_r   <= gsr_pkg::crc8(rd_val, gsr_pkg::WORD_BITS);
		end
		else if (last && phase_r == gsr_pkg::PH_DATA && wcrc && !is_wr)
			sh_out_r <= {rcrc_r, 24'h00_0000};
		else if (fall)
			sh_out_r <= {sh_out_r[30:0], 1'b0};
	end

	// The line is released while deselected so the strap stays readable.
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			sdo_r    <= 1'b0;
			sdo_oe_r <= 1'b0;
		end
		else
		begin
			// Only the read data and read check byte phases drive the line.
			sdo_oe_r <= active && !is_wr && (phase_r == gsr_pkg::PH_DATA
				|| phase_r == gsr_pkg::PH_DCRC);
			if (!active)
				sdo_r <= 1'b0;
			else if (fall)
				sdo_r <= sh_out_r[31];
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			err_r <= 1'b0;
		else
			err_r <= last && ((phase_r == gsr_pkg::PH_HDR && start_bad)
				|| (phase_r == gsr_pkg::PH_HCRC && hcrc_bad)
				|| (phase_r == gsr_pkg::PH_DCRC && is_wr && dcrc_bad));
	end

	assign spi.sdo_drv = sdo_r;
	assign spi.sdo_oe  = sdo_oe_r & active;
	assign crc_en_o    = crc_en_r;
	assign link_err_o  = err_r;

endmodule

// ==== gsr_host.sv ====
// Host end: drives serial transactions from a word command port.
`timescale 1ns/1ps
module gsr_host (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// Serial link
	gsr_spi_if.host          spi,
	// Command port
	input  wire logic        cmd_valid_i,
	output logic             cmd_ready_o,
	input  wire logic        cmd_write_i,
	input  wire logic [12:0] cmd_addr_i,
	input  wire logic [7:0]  cmd_words_i,
	input  wire logic        crc_en_i,
	// Data port
	input  wire logic [31:0] wr_data_i,
	output logic             wr_take_o,
	output logic [31:0]      rd_data_o,
	output logic             rd_valid_o,
	output logic             crc_err_o
);

	localparam logic [3:0] HALF_M1  = 4'(gsr_pkg::SCLK_HALF - 1);
	localparam logic [3:0] DIV_LAST = 4'(2 * gsr_pkg::SCLK_HALF - 1);

	gsr_pkg::gsr_phase_t phase_r;
	gsr_pkg::gsr_phase_t ph_nxt;
	logic                sdo_s1, sdo_s2;
	logic                cs_n_r;
	logic                sclk_r;
	logic [3:0]          div_r;
	logic [5:0]          cnt_r;
	logic [15:0]         hdr_r;
	logic                dir_r;
	logic [12:0]         addr_r;
	logic [7:0]          words_r;
	logic                crc_on_r;
	logic [31:0]         tx_r;
	logic [31:0]         rx_r;
	logic [31:0]         wbuf_r;

	logic        accept, bit_end, fld_end, wcrc, last_word, load_wr, done;
	logic [31:0] rx_new;

	assign accept    = cmd_valid_i && cmd_ready_o;
	assign bit_end   = (phase_r != gsr_pkg::PH_IDLE) && (div_r == DIV_LAST);
	assign fld_end   = bit_end && (cnt_r == gsr_pkg::field_last(phase_r));
	assign wcrc      = crc_on_r && !gsr_pkg::is_data_space(addr_r);
	assign last_word = (words_r <= 8'h01);
	assign rx_new    = {rx_r[30:0], sdo_s2};

	always_comb
	begin
		ph_nxt  = phase_r;
		load_wr = 1'b0;
		done    = 1'b0;
		case (phase_r)
			gsr_pkg::PH_HDR:
				if (crc_on_r)
					ph_nxt = gsr_pkg::PH_HCRC;
				else if (dir_r)
				begin
					ph_nxt  = gsr_pkg::PH_DATA;
					load_wr = 1'b1;
				end
				else
					ph_nxt = gsr_pkg::PH_TA;
			gsr_pkg::PH_HCRC:
				if (dir_r)
				begin
					ph_nxt  = gsr_pkg::PH_DATA;
					load_wr = 1'b1;
				end
				else
					ph_nxt = gsr_pkg::PH_TA;
			gsr_pkg::PH_TA:
				ph_nxt = gsr_pkg::PH_DATA;
			gsr_pkg::PH_DATA:
				if (wcrc)
					ph_nxt = gsr_pkg::PH_DCRC;
				else if (last_word)
					done = 1'b1;
				else
					load_wr = dir_r;
			gsr_pkg::PH_DCRC:
				if (last_word)
					done = 1'b1;
				else
				begin
					ph_nxt  = gsr_pkg::PH_DATA;
					load_wr = dir_r;
				end
			default:
				ph_nxt = phase_r;
		endcase
		if (done)
			ph_nxt = gsr_pkg::PH_IDLE;
	end

	assign cmd_ready_o = (phase_r == gsr_pkg::PH_IDLE);
	assign wr_take_o   = fld_end && load_wr;

	always_ff @(posedge clk_sys_i)
	begin
		sdo_s1 <= spi.sdo;
		sdo_s2 <= sdo_s1;
	end

	// Clock is low for the first half of each bit and idles low.
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			phase_r <= gsr_pkg::PH_IDLE;
			cs_n_r  <= 1'b1;
			sclk_r  <= 1'b0;
			div_r   <= 4'h0;
			cnt_r   <= 6'h00;
		end
		else if (accept)
		begin
			phase_r <= gsr_pkg::PH_HDR;
			cs_n_r  <= 1'b0;
			sclk_r  <= 1'b0;
			div_r   <= 4'h0;
			cnt_r   <= 6'h00;
		end
		else if (phase_r != gsr_pkg::PH_IDLE)
		begin
			div_r <= bit_end ? 4'h0 : div_r + 4'h1;
			if (div_r == HALF_M1)
				sclk_r <= 1'b1;
			if (bit_end)
			begin
				sclk_r <= 1'b0;
				cnt_r  <= fld_end ? 6'h00 : cnt_r + 6'h01;
			end
			if (fld_end)
			begin
				phase_r <= ph_nxt;
				if (done)
					cs_n_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			hdr_r    <= 16'h0000;
			dir_r    <= 1'b0;
			addr_r   <= 13'h0000;
			words_r  <= 8'h00;
			crc_on_r <= 1'b0;
		end
		else if (accept)
		begin
			hdr_r    <= {gsr_pkg::START_CODE, cmd_write_i, cmd_addr_i};
			dir_r    <= cmd_write_i;
			addr_r   <= cmd_addr_i;
			words_r  <= cmd_words_i;
			crc_on_r <= crc_en_i;
		end
		else if (fld_end && !done && ph_nxt == gsr_pkg::PH_DATA
			&& (phase_r == gsr_pkg::PH_DATA || phase_r == gsr_pkg::PH_DCRC))
			words_r <= words_r - 8'h01;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			tx_r <= 32'h0000_0000;
		else if (accept)
			tx_r <= {gsr_pkg::START_CODE, cmd_write_i, cmd_addr_i, 16'h0000};
		else if (fld_end)
		begin
			case (ph_nxt)
				gsr_pkg::PH_HCRC:
					tx_r <= {gsr_pkg::crc8({hdr_r, 16'h0000},
						gsr_pkg::HDR_BITS), 24'h00_0000};
				gsr_pkg::PH_DCRC:
					tx_r <= dir_r ? {gsr_pkg::crc8(wbuf_r, gsr_pkg::WORD_BITS),
						24'h00_0000} : 32'h0000_0000;
				gsr_pkg::PH_DATA:
					tx_r <= load_wr ? wr_data_i : 32'h0000_0000;
				default:
					tx_r <= 32'h0000_0000;
			endcase
		end
		else if (bit_end)
			tx_r <= {tx_r[30:0], 1'b0};
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			wbuf_r <= 32'h0000_0000;
		else if (wr_take_o)
			wbuf_r <= wr_data_i;
	end

	// Read bits are taken at the end of each bit, well after the device
	// has moved the line on the previous falling edge.
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			rx_r       <= 32'h0000_0000;
			rd_data_o  <= 32'h0000_0000;
			rd_valid_o <= 1'b0;
			crc_err_o  <= 1'b0;
		end
		else
		begin
			rd_valid_o <= 1'b0;
			if (accept)
				crc_err_o <= 1'b0;
			if (bit_end)
				rx_r <= rx_new;
			if (fld_end && !dir_r && phase_r == gsr_pkg::PH_DATA)
			begin
				rd_data_o  <= rx_new;
				rd_valid_o <= 1'b1;
			end
			// Sticky until the next command so a late check still sees it.
			if (fld_end && !dir_r && phase_r == gsr_pkg::PH_DCRC
				&& gsr_pkg::crc8(rd_data_o, gsr_pkg::WORD_BITS) != rx_new[7:0])
				crc_err_o <= 1'b1;
		end
	end

	assign spi.sclk = sclk_r;
	assign spi.cs_n = cs_n_r;
	assign spi.sdi  = tx_r[31];

endmodule

// ==== gsr_asserts.sv ====
// Timing and framing checks on the serial link between the two ends.
`timescale 1ns/1ps
module gsr_asserts (
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	// Serial link
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic sdi,
	input  wire logic sdo_drv,
	input  wire logic sdo_oe,
	input  wire logic sdo_strap,
	input  wire logic sdo
);
	logic       sclk_r;
	logic [9:0] bits_r;
	logic [2:0] hdr_r;

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	always_ff @(posedge clk_sys_i)
		sclk_r <= sclk;

	// Counts link clock rises in a frame; a deselect clears it.
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i || cs_n)
			bits_r <= 10'h000;
		else if (sclk && !sclk_r)
			bits_r <= bits_r + 10'h001;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!cs_n && sclk && !sclk_r && bits_r < 10'h003)
			hdr_r <= {hdr_r[1:0], sdi};
	end

	chk_idle_clock: assert property (
		cs_n && $past(cs_n) |-> $stable(sclk))
		else $error("link clock moved while deselected");
	chk_select_low: assert property ($fell(cs_n) |-> !sclk)
		else $error("select fell with link clock high");
	chk_release_out: assert property (cs_n [*3] |-> !sdo_oe)
		else $error("output line driven while deselected");
	chk_clock_high: assert property ($rose(sclk) |-> sclk [*4])
		else $error("link clock high phase too short");
	chk_clock_low: assert property ($fell(sclk) |-> !sclk [*4])
		else $error("link clock low phase too short");
	chk_sdi_steady: assert property ($rose(sclk) |-> $stable(sdi))
		else $error("input data moved at the sampling edge");
	chk_sdo_steady: assert property (
		$rose(sclk) && sdo_oe |-> $stable(sdo_drv))
		else $error("output data moved at the sampling edge");
	chk_whole_bytes: assert property (
		$rose(cs_n) |-> bits_r[2:0] == 3'h0 && bits_r >= 10'h030)
		else $error("frame not a whole number of bytes");
	chk_start_bits: assert property (
		!cs_n && bits_r == 10'h003 |-> hdr_r[2:1] == 2'h2)
		else $error("header start bits wrong");
	chk_read_drive: assert property (
		sdo_oe && !cs_n |-> hdr_r[0] == 1'b0 && bits_r >= 10'h018)
		else $error("output driven outside a read data phase");
endmodule

// ==== tb_generic_spi_register_access.sv ====
// Self-checking bench: host end and device end joined over the link.
`timescale 1ns/1ps
module tb_generic_spi_register_access;
	logic        clk_sys_i, rst_i, cmd_valid, cmd_ready, cmd_write;
	logic        host_crc, wr_take, rd_valid, crc_err, crc_en, link_err;
	logic        reg_wr, phy_sel, armed;
	logic [12:0] cmd_addr, reg_addr;
	logic [7:0]  cmd_words;
	logic [31:0] wr_data, rd_data, reg_wdata, reg_rdata, seed;
	logic [3:0]  reg_be;
	logic [15:0] hdr, hdr_exp;
	logic [44:0] e_w;
	logic [31:0] mem [0:8191] = '{default: 32'h0};
	logic [31:0] model [0:8191] = '{default: 32'h0};
	logic [44:0] exp_wq [$];
	logic [31:0] exp_rq [$];
	logic [31:0] wq [$];
	int          error_cnt, cmp_count, bits, bits_exp;
	gsr_pkg::gsr_access_t reg_kind;

	gsr_spi_if bus ();
	gsr_host gsr_host_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .spi(bus),
		.cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
		.cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr),
		.cmd_words_i(cmd_words), .crc_en_i(host_crc), .wr_data_i(wr_data),
		.wr_take_o(wr_take), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
		.crc_err_o(crc_err));
	gsr_dev gsr_dev_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .spi(bus),
		.proto_cfg_i(gsr_pkg::GENERIC_LEVEL), .crc_en_o(crc_en),
		.link_err_o(link_err), .reg_wr_o(reg_wr), .reg_rd_o(),
		.reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_be_o(reg_be),
		.phy_sel_o(phy_sel), .reg_kind_i(reg_kind), .reg_rdata_i(reg_rdata));
	gsr_asserts gsr_asserts_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.sclk(bus.sclk), .cs_n(bus.cs_n), .sdi(bus.sdi),
		.sdo_drv(bus.sdo_drv), .sdo_oe(bus.sdo_oe),
		.sdo_strap(bus.sdo_strap), .sdo(bus.sdo));

	// One read-only word guards the write-kind gating.
	assign reg_kind = (reg_addr == 13'h01F0) ? gsr_pkg::ACC_RO
		: gsr_pkg::ACC_RW;
	assign reg_rdata = mem[reg_addr];

	initial
	begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic do_reset(input logic c);
		@(negedge clk_sys_i);
		rst_i = 1'b1;
		bus.sdo_strap = c;
		host_crc = c;
		repeat (4) @(negedge clk_sys_i);
		rst_i = 1'b0;
		repeat (10) @(negedge clk_sys_i);
		check(crc_en, c);
	endtask

	// Words are sent whole; the model follows each accepted write.
	task automatic run(input logic wr, input logic [12:0] a, input int n);
		logic [12:0] k;
		logic [31:0] d;
		int          t;
		hdr_exp = {2'b10, wr, a};
		bits_exp = 16 + (wr ? 0 : 8) + 32 * n + (host_crc ? 8 + 8 * n : 0);
		for (int i = 0; i < n; i++)
		begin
			k = a + i[12:0];
			d = rnd();
			if (!wr)
				exp_rq.push_back(model[k]);
			else
				wq.push_back(d);
			if (wr && k != 13'h01F0)
			begin
				model[k] = d;
				exp_wq.push_back({k, d});
			end
		end
		@(negedge clk_sys_i);
		armed = 1'b1;
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_addr = a;
		cmd_words = n[7:0];
		do @(posedge clk_sys_i); while (cmd_ready !== 1'b1);
		@(negedge clk_sys_i);
		cmd_valid = 1'b0;
		for (t = 0; t < 200 && bus.cs_n !== 1'b0; t++) @(negedge clk_sys_i);
		for (t = 0; t < 9000 && bus.cs_n !== 1'b1; t++) @(negedge clk_sys_i);
		repeat (40) @(negedge clk_sys_i);
		check(exp_wq.size() + exp_rq.size(), 0);
		check({link_err, crc_err}, 2'h0);
	endtask

	always @(negedge clk_sys_i)
		wr_data <= (wq.size() > 0) ? wq[0] : ~wr_data;

	always @(posedge clk_sys_i)
	begin
		if (wr_take === 1'b1 && wq.size() > 0)
			void'(wq.pop_front());
		if (rst_i === 1'b0 && reg_wr === 1'b1)
		begin
			e_w = (exp_wq.size() > 0) ? exp_wq.pop_front() : 'x;
			check({reg_addr, reg_wdata}, e_w);
			check(reg_be, 4'hF);
			check(phy_sel, e_w[44:32] >= gsr_pkg::ADDR_PHY_MIN);
			mem[reg_addr] <= reg_wdata;
		end
		if (rst_i === 1'b0 && rd_valid === 1'b1)
			check(rd_data, (exp_rq.size() > 0) ? exp_rq.pop_front() : 'x);
	end

	always @(negedge bus.cs_n)
		bits = 0;

	always @(posedge bus.sclk)
	begin
		if (bus.cs_n === 1'b0 && bits < 16)
			hdr = {hdr[14:0], bus.sdi};
		bits++;
	end

	always @(posedge bus.cs_n)
	begin
		if (armed === 1'b1)
		begin
			check(hdr, hdr_exp);
			check(bits, bits_exp);
			armed = 1'b0;
		end
	end

	initial
	begin
		repeat (60000) @(posedge clk_sys_i);
		error_cnt++;
		conclude();
	end

	initial
	begin
		logic [31:0] r;
		seed = 32'hA669;
		armed = 1'b0;
		rst_i = 1'b1;
		{cmd_valid, cmd_write, cmd_addr, cmd_words, wr_data} = '0;
		bus.sdo_strap = 1'b0;
		host_crc = 1'b0;
		mem[13'h01F0] = 32'h5A5A0F0F;
		model[13'h01F0] = 32'h5A5A0F0F;
		do_reset(1'b0);
		run(1'b1, 13'h0104, 1);
		run(1'b0, 13'h0104, 1);
		run(1'b1, 13'h0140, 3);
		run(1'b0, 13'h0140, 3);
		run(1'b1, 13'h01F0, 1);
		run(1'b0, 13'h01F0, 1);
		run(1'b1, 13'h1004, 1);
		repeat (4)
		begin
			r = rnd();
			run(r[31], {5'h01, 1'b0, r[6:0]}, 1 + r[9:8]);
		end
		do_reset(1'b1);
		run(1'b1, 13'h0120, 2);
		run(1'b0, 13'h0120, 2);
		conclude();
	end
endmodule
